// [hdl/voc_osc_regs.svh]
// register offsets, field positions, reset values and constants
`ifndef VOC_OSC_REGS_SVH
`define VOC_OSC_REGS_SVH

// register indices; byte address is four times the index
`define VOC_IDX_TONE_LOW 6'h00
`define VOC_IDX_TONE_HIGH 6'h01
`define VOC_IDX_DUTY_LOW 6'h02
`define VOC_IDX_DUTY_HIGH 6'h03
`define VOC_IDX_CONTROL 6'h04

// voice control bit positions
`define VOC_BIT_GATE 0
`define VOC_BIT_SYNC 1
`define VOC_BIT_RING 2
`define VOC_BIT_TEST 3
`define VOC_BIT_TRI 4
`define VOC_BIT_SAW 5
`define VOC_BIT_PULSE 6
`define VOC_BIT_NOISE 7

// reset values
`define VOC_RST_BYTE 8'h00
`define VOC_RST_ACC 24'h000000
`define VOC_RST_LFSR 23'h7FFFFF

// accumulator bit that steps the noise source
`define VOC_NOISE_TAP 19

`endif

// [hdl/voc_pkg.sv]
// types shared by the voice oscillator block
`default_nettype none

package voc_pkg;

    // apb request from the host
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } voc_apb_req_s;

    // apb answer to the host
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } voc_apb_rsp_s;

    // whole state of the oscillator block
    typedef struct packed {
        logic [15:0] tune;     // tuning word
        logic [11:0] duty;     // pulse width word
        logic [7:0] ctrl;      // voice control byte
        logic [23:0] acc;      // phase accumulator
        logic osc3_msb;        // previous oscillator 3 msb
        logic noise_tap;       // previous noise step bit
        logic [22:0] lfsr;     // noise shift register
        logic [11:0] wave;     // combined waveform
        logic [11:0] voice;    // envelope-scaled voice
    } voc_state_s;

endpackage

`default_nettype wire

// [hdl/voc_osc.sv]
// voice 1 tone oscillator with its apb register file
`timescale 1ns/1ps
`default_nettype none
`include "voc_osc_regs.svh"

module voc_osc (
    input wire logic ref_clk_i,                  // system clock, 25 MHz
    input wire logic sys_rst_i,                  // async reset, high
    input wire voc_pkg::voc_apb_req_s apb_req_i, // apb request
    output var voc_pkg::voc_apb_rsp_s apb_rsp_o, // apb answer
    input wire logic osc3_msb_i,                 // oscillator 3 msb
    input wire logic [7:0] env_level_i,          // envelope amplitude
    output logic osc_msb_o,                      // own msb, for voice 2
    output logic gate_o,                         // envelope trigger level
    output logic [11:0] wave_o,                  // raw combined waveform
    output logic [11:0] voice_o                  // envelope-scaled voice
);

    // register index from an aligned byte address
    function automatic logic [5:0] voc_index(input logic [7:0] addr);
        voc_index = addr[7:2];
    endfunction

    // true when the address hits one of the five registers
    function automatic logic voc_mapped(input logic [7:0] addr);
        voc_mapped = (addr[1:0] == 2'h0) &&
                     (voc_index(addr) <= `VOC_IDX_CONTROL);
    endfunction

    voc_pkg::voc_state_s st_q; // registered state
    voc_pkg::voc_state_s st_d; // next state

    logic access; // apb access phase
    logic wr_en; // write taking effect this edge
    logic [5:0] idx; // decoded register index
    logic test; // oscillator held
    logic sync_hit; // oscillator 3 msb rising with sync on
    logic noise_step; // noise source advance
    logic tri_msb; // triangle fold bit, maybe ring modulated
    logic [11:0] tri_w; // triangle wave
    logic [11:0] saw_w; // sawtooth wave
    logic [11:0] pulse_w; // pulse wave
    logic [11:0] noise_w; // noise wave
    logic [11:0] mix_w; // AND of selected waves
    logic [19:0] scaled; // wave times envelope

    // zero-wait slave; unmapped addresses answer with an error
    always_comb begin
        access = apb_req_i.psel && apb_req_i.penable;
        idx = voc_index(apb_req_i.paddr);
        wr_en = access && apb_req_i.pwrite && apb_req_i.pstrb[0] &&
                voc_mapped(apb_req_i.paddr);
        apb_rsp_o.pready = 1'b1;
        apb_rsp_o.pslverr = access && !voc_mapped(apb_req_i.paddr);
        apb_rsp_o.prdata = 32'h00000000;
    end

    // waveform generation from the present accumulator
    always_comb begin
        test = st_q.ctrl[`VOC_BIT_TEST];
        // a rising msb only occurs if oscillator 3 steps at all
        sync_hit = st_q.ctrl[`VOC_BIT_SYNC] && osc3_msb_i &&
                   !st_q.osc3_msb;
        noise_step = st_q.acc[`VOC_NOISE_TAP] && !st_q.noise_tap;
        // ring: oscillator 3 msb flips the fold of the triangle
        tri_msb = st_q.acc[23] ^
                  (st_q.ctrl[`VOC_BIT_RING] && osc3_msb_i);
        tri_w = tri_msb ? ~st_q.acc[22:11] : st_q.acc[22:11];
        saw_w = st_q.acc[23:12];
        // duty compare; full-scale word pins the output high
        if (test) begin
            pulse_w = 12'hFFF;
        end else if (st_q.duty == 12'hFFF) begin
            pulse_w = 12'hFFF;
        end else if (st_q.acc[23:12] < st_q.duty) begin
            pulse_w = 12'hFFF;
        end else begin
            pulse_w = 12'h000;
        end
        noise_w = {st_q.lfsr[22], st_q.lfsr[20], st_q.lfsr[16],
                   st_q.lfsr[13], st_q.lfsr[11], st_q.lfsr[7],
                   st_q.lfsr[4], st_q.lfsr[2], 4'h0};
        // selected waves are ANDed, none selected gives zero
        mix_w = 12'hFFF;
        if (st_q.ctrl[`VOC_BIT_TRI]) begin
            mix_w = mix_w & tri_w;
        end
        if (st_q.ctrl[`VOC_BIT_SAW]) begin
            mix_w = mix_w & saw_w;
        end
        if (st_q.ctrl[`VOC_BIT_PULSE]) begin
            mix_w = mix_w & pulse_w;
        end
        if (st_q.ctrl[`VOC_BIT_NOISE]) begin
            mix_w = mix_w & noise_w;
        end
        if (st_q.ctrl[7:4] == 4'h0) begin
            mix_w = 12'h000;
        end
        scaled = st_q.wave * env_level_i;
    end

    // next state: registers, accumulator, noise, outputs
    always_comb begin
        st_d = st_q;
        // register writes, low byte lane only
        if (wr_en) begin
            case (idx)
                `VOC_IDX_TONE_LOW: begin
                    st_d.tune[7:0] = apb_req_i.pwdata[7:0];
                end
                `VOC_IDX_TONE_HIGH: begin
                    st_d.tune[15:8] = apb_req_i.pwdata[7:0];
                end
                `VOC_IDX_DUTY_LOW: begin
                    st_d.duty[7:0] = apb_req_i.pwdata[7:0];
                end
                `VOC_IDX_DUTY_HIGH: begin
                    st_d.duty[11:8] = apb_req_i.pwdata[3:0];
                end
                `VOC_IDX_CONTROL: begin
                    st_d.ctrl = apb_req_i.pwdata[7:0];
                end
                default: begin
                    st_d.ctrl = st_q.ctrl; // unmapped, nothing stored
                end
            endcase
        end
        // phase accumulator; test wins over sync and stepping
        if (test) begin
            st_d.acc = `VOC_RST_ACC;
        end else if (sync_hit) begin
            st_d.acc = `VOC_RST_ACC;
        end else begin
            st_d.acc = st_q.acc + {8'h00, st_q.tune};
        end
        st_d.osc3_msb = osc3_msb_i;
        st_d.noise_tap = st_q.acc[`VOC_NOISE_TAP];
        // noise source steps on each rise of the tap bit
        if (test) begin
            st_d.lfsr = `VOC_RST_LFSR;
        end else if (noise_step) begin
            st_d.lfsr = {st_q.lfsr[21:0], st_q.lfsr[22] ^ st_q.lfsr[17]};
        end
        st_d.wave = mix_w;
        st_d.voice = scaled[19:8];
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q.tune <= {`VOC_RST_BYTE, `VOC_RST_BYTE};
            st_q.duty <= 12'h000;
            st_q.ctrl <= `VOC_RST_BYTE;
            st_q.acc <= `VOC_RST_ACC;
            st_q.osc3_msb <= 1'b0;
            st_q.noise_tap <= 1'b0;
            st_q.lfsr <= `VOC_RST_LFSR;
            st_q.wave <= 12'h000;
            st_q.voice <= 12'h000;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state
    always_comb begin
        osc_msb_o = st_q.acc[23];
        gate_o = st_q.ctrl[`VOC_BIT_GATE];
        wave_o = st_q.wave;
        voice_o = st_q.voice;
    end

    // accumulator held at zero one cycle after test is seen
    property p_test_hold;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        st_q.ctrl[`VOC_BIT_TEST] |=> (st_q.acc == 24'h000000);
    endproperty
    a_test_hold: assert property (p_test_hold)
        else $error("accumulator not held by test");

    // free running accumulator steps by the tuning word
    property p_step;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (!test && !sync_hit) |=>
            (st_q.acc == $past(st_q.acc) + {8'h00, $past(st_q.tune)});
    endproperty
    a_step: assert property (p_step)
        else $error("accumulator step wrong");

    // sync edge clears the accumulator
    property p_sync;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q.ctrl[`VOC_BIT_SYNC] && osc3_msb_i && !st_q.osc3_msb)
            |=> (st_q.acc == 24'h000000);
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync did not clear accumulator");

    // high duty byte keeps only its low nibble
    property p_duty_high;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr_en && idx == `VOC_IDX_DUTY_HIGH) |=>
            (st_q.duty[11:8] == $past(apb_req_i.pwdata[3:0]));
    endproperty
    a_duty_high: assert property (p_duty_high)
        else $error("duty high nibble wrong");

    // high tone byte lands in the upper eight bits
    property p_tone_high;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr_en && idx == `VOC_IDX_TONE_HIGH) |=>
            (st_q.tune[15:8] == $past(apb_req_i.pwdata[7:0]));
    endproperty
    a_tone_high: assert property (p_tone_high)
        else $error("tone high byte wrong");

    // reads always return zero
    property p_read_zero;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (access && !apb_req_i.pwrite) |-> (apb_rsp_o.prdata == 32'h0);
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("register read returned data");

    // control write drives the gate output next cycle
    property p_gate;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr_en && idx == `VOC_IDX_CONTROL) |=>
            (gate_o == $past(apb_req_i.pwdata[0]));
    endproperty
    a_gate: assert property (p_gate)
        else $error("gate output does not follow write");

    // no wave selected gives a silent raw output
    property p_none;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q.ctrl[7:4] == 4'h0) |=> (wave_o == 12'h000);
    endproperty
    a_none: assert property (p_none)
        else $error("output with no wave selected");

    // zero envelope level silences the voice on the next cycle
    property p_silent;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (env_level_i == 8'h00) |=> (voice_o == 12'h000);
    endproperty
    a_silent: assert property (p_silent)
        else $error("voice audible at zero envelope");

    // pulse alone with duty zero stays low
    property p_pulse_dc;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q.ctrl[7:4] == 4'h4 && st_q.duty == 12'h000 && !test)
            |=> (wave_o == 12'h000);
    endproperty
    a_pulse_dc: assert property (p_pulse_dc)
        else $error("pulse not DC at duty zero");

    // low tone byte lands in the lower eight bits
    property p_tone_low;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr_en && idx == `VOC_IDX_TONE_LOW) |=>
            (st_q.tune[7:0] == $past(apb_req_i.pwdata[7:0]));
    endproperty
    a_tone_low: assert property (p_tone_low)
        else $error("tone low byte wrong");

    // low duty byte lands in the lower eight bits
    property p_duty_low;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr_en && idx == `VOC_IDX_DUTY_LOW) |=>
            (st_q.duty[7:0] == $past(apb_req_i.pwdata[7:0]));
    endproperty
    a_duty_low: assert property (p_duty_low)
        else $error("duty low byte wrong");

    // a refused write leaves every register as it was
    property p_no_store;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (access && apb_req_i.pwrite && !voc_mapped(apb_req_i.paddr)) |=>
            (st_q.tune == $past(st_q.tune) &&
             st_q.duty == $past(st_q.duty) &&
             st_q.ctrl == $past(st_q.ctrl));
    endproperty
    a_no_store: assert property (p_no_store)
        else $error("refused write changed a register");

    // test puts the noise source back to its seed
    property p_noise_seed;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        test |=> (st_q.lfsr == `VOC_RST_LFSR);
    endproperty
    a_noise_seed: assert property (p_noise_seed)
        else $error("noise source not reset by test");

    // full-scale duty word pins a lone pulse high
    property p_pulse_full;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q.ctrl[7:4] == 4'h4 && st_q.duty == 12'hFFF)
            |=> (wave_o == 12'hFFF);
    endproperty
    a_pulse_full: assert property (p_pulse_full)
        else $error("pulse not DC at full-scale duty");

    // lone sawtooth shows the top accumulator bits
    property p_saw;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q.ctrl[7:4] == 4'h2) |=> (wave_o == $past(st_q.acc[23:12]));
    endproperty
    a_saw: assert property (p_saw)
        else $error("sawtooth wave wrong");

    // plain triangle folds on the accumulator msb alone
    property p_tri;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q.ctrl[7:4] == 4'h1 && !st_q.ctrl[`VOC_BIT_RING])
            |=> (wave_o[11] == ($past(st_q.acc[23]) != $past(st_q.acc[22])));
    endproperty
    a_tri: assert property (p_tri)
        else $error("triangle fold wrong");

    // ring bit with oscillator 3 high flips the triangle fold
    property p_ring;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (st_q.ctrl[7:4] == 4'h1 && st_q.ctrl[`VOC_BIT_RING] && osc3_msb_i)
            |=> (wave_o[11] == ($past(st_q.acc[23]) == $past(st_q.acc[22])));
    endproperty
    a_ring: assert property (p_ring)
        else $error("ring product fold wrong");

endmodule // voc_osc

`default_nettype wire

// [sim/voc_host_model.sv]
// apb host model that issues register transfers to the voice block
`timescale 1ns/1ps
`default_nettype none

module voc_host_model (
    input wire logic clk_i,                   // bus clock
    output var voc_pkg::voc_apb_req_s req_o,  // apb request
    input wire voc_pkg::voc_apb_rsp_s rsp_i   // apb answer
);
    logic [7:0] shadow [0:4]; // own copy, reads give nothing back

    initial req_o = '0;

    // one transfer; ok stays low when pready never came
    task automatic xfer(input logic wr, input logic [7:0] ad,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e, output logic ok);
        int n;
        @(posedge clk_i);
        req_o <= '{1'b1, 1'b0, wr, ad, d, s};
        @(posedge clk_i);
        req_o.penable <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge clk_i);
            ok = (rsp_i.pready === 1'b1);
        end
        r = rsp_i.prdata;
        e = rsp_i.pslverr;
        // released lines no longer show the last value
        req_o <= '{1'b0, 1'b0, ~wr, ~ad, ~d, 4'h0};
        if (ok && wr && ad[1:0] == 2'h0 && ad[7:2] <= 6'h04 && s[0]) begin
            shadow[ad[4:2]] = d[7:0];
        end
    endtask
endmodule // voc_host_model

`default_nettype wire

// [sim/voice_oscillator_control_tb.sv]
// self-checking bench for the voice oscillator block
`timescale 1ns/1ps
`default_nettype none

module voice_oscillator_control_tb;
    logic ref_clk_i = 1'b0; // 25 MHz clock
    logic sys_rst_i = 1'b1; // reset, high
    logic osc3 = 1'b0; // oscillator 3 msb
    logic [7:0] env = 8'h00; // envelope level
    voc_pkg::voc_apb_req_s req; // bus request
    voc_pkg::voc_apb_rsp_s rsp; // bus answer
    logic msb, gate; // voice flags
    logic [11:0] wave, voice, a; // waveforms, last sample
    int n_fail = 0;
    int checked = 0;
    int cnt, c2, i, k; // tallies, loop indices
    logic [7:0] dl [4] = '{8'h00, 8'h00, 8'hFF, 8'h00}; // duty low
    logic [7:0] dh [4] = '{8'h00, 8'hF8, 8'hFF, 8'h04}; // duty high
    int dn [4] = '{0, 2048, 4096, 1024}; // high cycles a period
    logic [7:0] rc [4] = '{8'h14, 8'h14, 8'h10, 8'h24}; // ring ctrl
    logic [3:0] rx [4] = '{4'h9, 4'h0, 4'h8, 4'h8}; // osc3, msb
    logic [11:0] rs [4] = '{12'hFFF, 12'h001, 12'h001, 12'h000};

    voc_osc dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .apb_req_i(req), .apb_rsp_o(rsp), .osc3_msb_i(osc3),
        .env_level_i(env), .osc_msb_o(msb), .gate_o(gate),
        .wave_o(wave), .voice_o(voice));
    voc_host_model host (.clk_i(ref_clk_i), .req_o(req), .rsp_i(rsp));

    // free-running clock, 40 ns period
    initial forever #20 ref_clk_i = ~ref_clk_i;

    task automatic end_of_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // compare and report
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // one apb transfer; reads must give zero
    task automatic bus(input logic w, input logic [7:0] ad,
        input logic [7:0] d, input logic [3:0] s = 4'h1,
        input logic ex = 1'b0);
        logic [31:0] r;
        logic e, ok;
        host.xfer(w, ad, {24'h0, d}, s, r, e, ok);
        if (!ok) begin
            n_fail++;
            $display("ERROR %0t: no bus answer", $time);
            end_of_test();
        end
        chk({15'h0, e}, {15'h0, ex});
        if (!w) chk(r[15:0], 16'h0000);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        cyc(1);
        chk({3'h0, gate, wave}, 16'h0000);
        for (i = 0; i < 5; i++) bus(1'b0, 8'(i * 4), 8'h00);
        bus(1'b0, 8'h14, 8'h00, 4'h1, 1'b1);
        bus(1'b1, 8'h01, 8'h01, 4'h1, 1'b1);
        // noise seed and pulse held under test
        bus(1'b1, 8'h10, 8'h88);
        cyc(3);
        chk(wave, 16'h0FF0);
        bus(1'b1, 8'h10, 8'h49);
        @(posedge ref_clk_i) env <= 8'h80;
        cyc(3);
        chk(wave, 16'h0FFF);
        chk(gate, 16'h0001);
        chk(voice, 16'h07FF);
        @(posedge ref_clk_i) env <= 8'h00;
        cyc(3);
        chk(voice, 16'h0000);
        bus(1'b1, 8'h10, 8'h48);
        cyc(1);
        chk(gate, 16'h0000);
        bus(1'b1, 8'h10, 8'h49, 4'h0);
        cyc(1);
        chk(gate, 16'h0000);
        // sawtooth step rate from the high tone byte
        for (i = 1; i < 4; i += 2) begin
            bus(1'b1, 8'h04, 8'(i * 16));
            bus(1'b1, 8'h00, 8'h00);
            bus(1'b1, 8'h10, 8'h28);
            bus(1'b1, 8'h10, 8'h20);
            cyc(2);
            a = wave;
            for (k = 0; k < 8; k++) begin
                cyc(1);
                a = a + 12'(i);
                chk(wave, a);
            end
        end
        // duty word sets high cycles over one period
        bus(1'b1, 8'h04, 8'h10);
        bus(1'b1, 8'h10, 8'h40);
        for (i = 0; i < 4; i++) begin
            bus(1'b1, 8'h08, dl[i]);
            bus(1'b1, 8'h0C, dh[i]);
            cnt = 0;
            c2 = 0;
            // first sample after the write still shows the old duty
            cyc(1);
            for (k = 0; k < 4096; k++) begin
                cyc(1);
                if (wave === 12'hFFF) cnt++;
                if (msb === 1'b1) c2++;
            end
            chk(16'(cnt), 16'(dn[i]));
            chk(16'(c2), 16'h0800);
        end
        // saw and square together are ANDed
        bus(1'b1, 8'h0C, 8'h08);
        bus(1'b1, 8'h10, 8'h60);
        cnt = 0;
        c2 = 0;
        cyc(1);
        for (k = 0; k < 4096; k++) begin
            cyc(1);
            if (wave[11] !== 1'b0) cnt++;
            if (wave !== 12'h000) c2++;
        end
        chk(16'(cnt), 16'h0000);
        chk(16'(c2), 16'h07FF);
        // triangle, ring product and its conditions
        bus(1'b1, 8'h04, 8'h08);
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk_i) osc3 <= rx[i][3];
            bus(1'b1, 8'h10, rc[i] | 8'h08);
            bus(1'b1, 8'h10, rc[i]);
            cyc(4);
            a = wave;
            chk(wave[11], {15'h0, rx[i][0]});
            cyc(1);
            a = a + rs[i];
            if (rs[i] != 12'h000) chk(wave, a);
        end
        // sync clears the phase on the oscillator 3 rise
        bus(1'b1, 8'h04, 8'h10);
        for (i = 0; i < 2; i++) begin
            @(posedge ref_clk_i) osc3 <= 1'b0;
            bus(1'b1, 8'h10, i ? 8'h28 : 8'h2A);
            bus(1'b1, 8'h10, i ? 8'h20 : 8'h22);
            cyc(100);
            @(posedge ref_clk_i) osc3 <= 1'b1;
            cyc(3);
            chk(wave <= 12'h003, 16'(i == 0));
        end
        // host copy holds the last control byte it stored
        chk({8'h00, host.shadow[4]}, 16'h0020);
        end_of_test();
    end
endmodule // voice_oscillator_control_tb

`default_nettype wire
